// >>> common/udtadc_if.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// count and mode from the tracker to the pin mapper
// ****************************************************************
interface udtadc_map_if
   import udtadc_pkg::*;
   #(parameter int CODE_W = 8);
   logic [CODE_W-1:0] count;
   udt_mode_t         mode;
   logic [CODE_W-1:0] dac_pins;
   logic [CODE_W-1:0] result;
   modport ctl (output count, output mode, input dac_pins, input result);
   modport map (input count, input mode, output dac_pins, output result);
endinterface
`default_nettype wire

// >>> common/udtadc_pkg.sv
package udtadc_pkg;
   // ****************************************************************
   // converter output modes and tracker states
   // ****************************************************************
   typedef enum logic [1:0] {
      UDT_MODE_ZERO_REF = 2'h0,
      UDT_MODE_ZERO_FS  = 2'h1,
      UDT_MODE_BIPOLAR  = 2'h2,
      UDT_MODE_RSVD     = 2'h3
   } udt_mode_t;

   typedef enum logic [1:0] {
      UDT_ST_IDLE  = 2'h0,
      UDT_ST_TRACK = 2'h1,
      UDT_ST_LOCK  = 2'h3
   } udt_state_t;
endpackage

// >>> common/udtadc_regs.svh
`ifndef UDTADC_REGS_SVH
`define UDTADC_REGS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define UDT_OFF_CTRL     8'h00
`define UDT_OFF_DIV      8'h04
`define UDT_OFF_STATUS   8'h08
`define UDT_OFF_CODE     8'h0c
`define UDT_OFF_IRQ_STAT 8'h10
`define UDT_OFF_IRQ_MASK 8'h14
// ****************************************************************
// field positions
// ****************************************************************
`define UDT_CTRL_RUN     0
`define UDT_CTRL_MODE_LO 1
`define UDT_CTRL_MODE_HI 2
`define UDT_ST_READY     0
`define UDT_ST_AT_MIN    1
`define UDT_ST_AT_MAX    2
`define UDT_ST_TRACK     3
`define UDT_EV_CHANGE    0
`define UDT_EV_READY     1
`define UDT_EV_LIMIT     2
// ****************************************************************
// reset values and timing counts
// ****************************************************************
`define UDT_CTRL_RST     3'h0
`define UDT_DIV_RST      16'h0000
`define UDT_MASK_RST     3'h0
`define UDT_CODE_RST     8'h00
`define UDT_ACQ_MAX      256
`endif

// >>> src/udtadc_map.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// binary count to converter pins and presented result
// ****************************************************************
module udtadc_map
   import udtadc_pkg::*;
(
   input  wire logic   core_clk,
   input  wire logic   reset_n,
   udtadc_map_if.map   mif
);
   // pin high parks a bit current at ground, low steers it to the
   // ladder; zero-reference mode therefore needs inverted codes
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mif.dac_pins <= '1;
         mif.result   <= '1;
      end else begin
         unique case (mif.mode)
            UDT_MODE_ZERO_REF: begin
               mif.dac_pins <= ~mif.count;
               mif.result   <= ~mif.count;
            end
            UDT_MODE_ZERO_FS: begin
               mif.dac_pins <= mif.count;
               mif.result   <= mif.count;
            end
            UDT_MODE_BIPOLAR: begin
               mif.dac_pins <= mif.count;
               mif.result   <= mif.count;
            end
            default: begin
               mif.dac_pins <= mif.count; // reserved acts as zero-fs
               mif.result   <= mif.count;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> src/udtadc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// three-stage input synchroniser with agreement filter
// ****************************************************************
module udtadc_sync #(
   parameter int W = 2
) (
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] pin,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // shift chain; first stage feeds only the second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // accept a new level per bit once stages two and three agree
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         level <= '0;
      end else begin
         level <= (s2_q & s3_q) | (level & (s2_q | s3_q));
      end
   end
endmodule
`default_nettype wire

// >>> src/udtadc_top.sv
// Behaviour
// - both comparators high: counter holds, data-ready asserted
// - outside window: count up or down each step, data-ready low
// - negative output mode presents the result in negative logic
// - counter moves at most one step per step pulse
// - acquisition may take up to 256 steps before data-ready
// - data-ready changes only when the balance condition or the run enable changes
// - data-ready change sets sticky flag; reader clears it after read
// - pin high parks bit current at ground, low feeds the ladder
// - zero-reference mode: low means one, larger code more negative
// - zero-full-scale mode: high means one, larger code more positive
// - bipolar: all low most negative, top bit only zero, all high +ref
`timescale 1ns/1ns
`default_nettype none
`include "udtadc_regs.svh"
module udtadc_top
   import udtadc_pkg::*;
#(
   parameter int CODE_W = 8,
   parameter int DIV_W  = 16
) (
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   // window comparators, high while inside their half-lsb limit
   input  wire logic              cmp_below_ok,
   input  wire logic              cmp_above_ok,
   // converter pins and results
   output logic [CODE_W-1:0]      dac_code,
   output logic [CODE_W-1:0]      result_code,
   output logic                   data_ready,
   output logic                   irq
);
   // ****************************************************************
   // declarations
   // ****************************************************************
   localparam int EV_W = 3;

   logic                dp_valid_q;
   logic                dp_write_q;
   logic [7:0]          dp_addr_q;
   logic                rd_ok_q;
   logic [31:0]         rdata_q;
   logic [31:0]         rdata_d;
   logic                wr_en;
   logic                addr_take;

   logic                run_q;
   udt_mode_t           mode_q;
   logic [DIV_W-1:0]    div_q;
   logic [DIV_W-1:0]    div_cnt_q;
   logic                step_en;

   logic [1:0]          cmp_level;
   logic                below_ok;
   logic                above_ok;
   logic                balanced;

   udt_state_t          state_q;
   udt_state_t          state_d;
   logic [CODE_W-1:0]   count_q;
   logic                at_min;
   logic                at_max;
   logic                want_up;
   logic                want_down;
   logic                limit_hit;

   logic                ready_prev_q;
   logic [EV_W-1:0]     ev_set;
   logic [EV_W-1:0]     ev_clr;
   logic [EV_W-1:0]     irq_stat_q;
   logic [EV_W-1:0]     irq_mask_q;

   udtadc_map_if #(.CODE_W(CODE_W)) map_bus ();

   // ****************************************************************
   // address decode helper
   // ****************************************************************
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ****************************************************************
   // ahb-lite slave: writes take no wait, reads take one
   // ****************************************************************
   assign addr_take = hsel & htrans[1] & hready;

   // capture the address phase of each accepted transfer
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dp_valid_q <= 1'b0;
         dp_write_q <= 1'b0;
         dp_addr_q  <= 8'h00;
      end else if (hready) begin
         dp_valid_q <= addr_take;
         dp_write_q <= hwrite;
         dp_addr_q  <= {haddr[7:2], 2'b00};
      end
   end

   // read wait state: first data-phase cycle loads the read register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ok_q <= 1'b0;
      end else begin
         rd_ok_q <= dp_valid_q & ~dp_write_q & ~rd_ok_q;
      end
   end

   assign hreadyout = ~(dp_valid_q & ~dp_write_q & ~rd_ok_q);
   assign hresp     = 1'b0;
   assign wr_en     = dp_valid_q & dp_write_q;

   // read multiplexer; unmapped words read as zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit(dp_addr_q, `UDT_OFF_CTRL)) begin
         rdata_d[`UDT_CTRL_RUN] = run_q;
         rdata_d[`UDT_CTRL_MODE_HI:`UDT_CTRL_MODE_LO] = mode_q;
      end else if (hit(dp_addr_q, `UDT_OFF_DIV)) begin
         rdata_d[DIV_W-1:0] = div_q;
      end else if (hit(dp_addr_q, `UDT_OFF_STATUS)) begin
         rdata_d[`UDT_ST_READY]  = data_ready;
         rdata_d[`UDT_ST_AT_MIN] = at_min;
         rdata_d[`UDT_ST_AT_MAX] = at_max;
         rdata_d[`UDT_ST_TRACK]  = (state_q == UDT_ST_TRACK);
      end else if (hit(dp_addr_q, `UDT_OFF_CODE)) begin
         rdata_d[CODE_W-1:0] = count_q;
      end else if (hit(dp_addr_q, `UDT_OFF_IRQ_STAT)) begin
         rdata_d[EV_W-1:0] = irq_stat_q;
      end else if (hit(dp_addr_q, `UDT_OFF_IRQ_MASK)) begin
         rdata_d[EV_W-1:0] = irq_mask_q;
      end
   end

   // read data register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (dp_valid_q & ~dp_write_q & ~rd_ok_q) begin
         rdata_q <= rdata_d;
      end
   end

   assign hrdata = rdata_q;

   // ****************************************************************
   // control registers
   // ****************************************************************
   // run enable and output mode
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         run_q  <= 1'b0;
         mode_q <= UDT_MODE_ZERO_REF;
      end else if (wr_en && hit(dp_addr_q, `UDT_OFF_CTRL)) begin
         run_q  <= hwdata[`UDT_CTRL_RUN];
         mode_q <= udt_mode_t'(hwdata[`UDT_CTRL_MODE_HI:`UDT_CTRL_MODE_LO]);
      end
   end

   // step divider reload value; zero steps on every clock
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_q <= `UDT_DIV_RST;
      end else if (wr_en && hit(dp_addr_q, `UDT_OFF_DIV)) begin
         div_q <= hwdata[DIV_W-1:0];
      end
   end

   // interrupt mask, same layout as the interrupt status word
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_mask_q <= `UDT_MASK_RST;
      end else if (wr_en && hit(dp_addr_q, `UDT_OFF_IRQ_MASK)) begin
         irq_mask_q <= hwdata[EV_W-1:0];
      end
   end

   // ****************************************************************
   // step clock divider
   // ****************************************************************
   // one-cycle step pulse every div_q+1 clocks
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_q <= '0;
      end else if (!run_q || div_cnt_q == '0) begin
         div_cnt_q <= div_q;
      end else begin
         div_cnt_q <= div_cnt_q - 1'b1;
      end
   end

   assign step_en = run_q & (div_cnt_q == '0);

   // ****************************************************************
   // comparator synchronisers
   // ****************************************************************
   udtadc_sync #(.W(2)) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .pin      ({cmp_above_ok, cmp_below_ok}),
      .level    (cmp_level)
   );

   assign below_ok = cmp_level[0];
   assign above_ok = cmp_level[1];
   assign balanced = below_ok & above_ok;

   // ****************************************************************
   // tracker state machine
   // ****************************************************************
   // lock follows the balance window while run is set, so ready moves only with it or with run
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         UDT_ST_IDLE: begin
            if (run_q) begin
               state_d = UDT_ST_TRACK;
            end
         end
         UDT_ST_TRACK: begin
            if (!run_q) begin
               state_d = UDT_ST_IDLE;
            end else if (balanced) begin
               state_d = UDT_ST_LOCK;
            end
         end
         UDT_ST_LOCK: begin
            if (!run_q) begin
               state_d = UDT_ST_IDLE;
            end else if (!balanced) begin
               state_d = UDT_ST_TRACK;
            end
         end
         default: begin
            state_d = UDT_ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= UDT_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // data-ready output flop, high only while locked
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_ready <= 1'b0;
      end else begin
         data_ready <= (state_d == UDT_ST_LOCK);
      end
   end

   // ****************************************************************
   // up/down counter
   // ****************************************************************
   assign at_min    = (count_q == '0);
   assign at_max    = (count_q == '1);
   // below window: converter short of input, so count up
   assign want_up   = ~below_ok & above_ok;
   assign want_down = below_ok & ~above_ok;
   assign limit_hit = (state_q == UDT_ST_TRACK) & step_en &
                      ((want_up & at_max) | (want_down & at_min));

   // one step per pulse, clamped at both ends; preset when stopped
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= `UDT_CODE_RST;
      end else if (!run_q) begin
         if (wr_en && hit(dp_addr_q, `UDT_OFF_CODE)) begin
            count_q <= hwdata[CODE_W-1:0];
         end
      end else if (state_q == UDT_ST_TRACK && step_en && !balanced) begin
         if (want_up && !at_max) begin
            count_q <= count_q + 1'b1;
         end else if (want_down && !at_min) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

   // ****************************************************************
   // converter pin mapping
   // ****************************************************************
   assign map_bus.count = count_q;
   assign map_bus.mode  = mode_q;

   // all code bits drive pins; cascading is wired outside
   udtadc_map u_map (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .mif      (map_bus)
   );

   assign dac_code    = map_bus.dac_pins;
   assign result_code = map_bus.result;

   // ****************************************************************
   // events and interrupt
   // ****************************************************************
   // previous data-ready level for edge detection
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ready_prev_q <= 1'b0;
      end else begin
         ready_prev_q <= data_ready;
      end
   end

   // event sources
   always_comb begin
      ev_set = '0;
      ev_set[`UDT_EV_CHANGE] = data_ready ^ ready_prev_q;
      ev_set[`UDT_EV_READY]  = data_ready & ~ready_prev_q;
      ev_set[`UDT_EV_LIMIT]  = limit_hit;
   end

   // write-one-to-clear strobes
   always_comb begin
      ev_clr = '0;
      if (wr_en && hit(dp_addr_q, `UDT_OFF_IRQ_STAT)) begin
         ev_clr = hwdata[EV_W-1:0];
      end
   end

   // sticky status, a new event beats a clear in the same cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~ev_clr) | ev_set;
      end
   end

   // level interrupt while any unmasked status bit stands
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_stat_q & ~ev_clr) | ev_set) & irq_mask_q);
      end
   end

endmodule
`default_nettype wire

// >>> verif/udtadc_partner.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// converter ladder and two window comparators
// ****************************************************************
module udtadc_partner (
   input  wire logic [7:0] dac_code,
   input  wire logic [1:0] mode,
   input  var  int         level,
   output logic            cmp_below_ok,
   output logic            cmp_above_ok
);
   int v;
   // single unit, so its top_bit_input stays in use
   // high pin parks current, low feeds the ladder
   // zero-ref reads negative logic, the others positive
   always_comb begin
      v = (mode == 2'h0) ? {24'h0, ~dac_code} : {24'h0, dac_code};
      cmp_below_ok = (v >= level);
      cmp_above_ok = (v <= level);
   end
endmodule
`default_nettype wire

// >>> verif/udtadc_props.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// port checks of the tracking converter
// ****************************************************************
module udtadc_props #(
   parameter int CODE_W = 8,
   parameter int DIV_W  = 16
) (
   input wire logic              core_clk,
   input wire logic              reset_n,
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [2:0]        hsize,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic              hreadyout,
   input wire logic [31:0]       hrdata,
   input wire logic              hresp,
   input wire logic              cmp_below_ok,
   input wire logic              cmp_above_ok,
   input wire logic [CODE_W-1:0] dac_code,
   input wire logic [CODE_W-1:0] result_code,
   input wire logic              data_ready,
   input wire logic              irq
);
   logic [3:0] bal_q;
   logic [3:0] wr_q;
   logic       rd_tk;
   logic       wr_tk;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   assign rd_tk = hsel && htrans[1] && hready && !hwrite;
   assign wr_tk = hsel && htrans[1] && hready && hwrite;
   // balanced run length and recent write history
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bal_q <= 4'h0;
         wr_q  <= 4'h0;
      end else begin
         wr_q <= {wr_q[2:0], wr_tk};
         if (!(cmp_below_ok && cmp_above_ok)) begin
            bal_q <= 4'h0;
         end else if (bal_q != 4'hf) begin
            bal_q <= bal_q + 4'h1;
         end
      end
   end
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   chk_read_wait: assert property (rd_tk |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (wr_tk |=> hreadyout)
      else $error("write stalled");
   chk_unmapped_zero: assert property (rd_tk && haddr[7:2] > 6'h05
      |=> ##1 hrdata == 32'h0000_0000) else $error("unmapped read nonzero");
   chk_pins_match: assert property (dac_code == result_code)
      else $error("pins and result differ");
   chk_step_one: assert property ($changed(dac_code) && wr_q == 4'h0
      |-> ({1'b0, dac_code} == {1'b0, $past(dac_code)} + 9'h001)
      || ({1'b0, dac_code} + 9'h001 == {1'b0, $past(dac_code)}))
      else $error("code moved more than one step");
   chk_unbal_low: assert property (
      (!(cmp_below_ok && cmp_above_ok))[*8] |-> !data_ready)
      else $error("ready while unbalanced");
   chk_ready_steady: assert property ($fell(data_ready) |-> bal_q < 4'hc)
      else $error("ready dropped while balanced");
   cov_lock: cover property ($rose(data_ready));
   cov_read: cover property (rd_tk);
   cov_irq: cover property ($rose(irq));
endmodule
bind udtadc_top udtadc_props #(.CODE_W(CODE_W), .DIV_W(DIV_W)) udtadc_props_inst (
   .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .cmp_below_ok(cmp_below_ok), .cmp_above_ok(cmp_above_ok),
   .dac_code(dac_code), .result_code(result_code),
   .data_ready(data_ready), .irq(irq));
`default_nettype wire

// >>> verif/udtadc_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "udtadc_regs.svh"
module udtadc_tb_top;
   logic        core_clk = 1'b0;
   logic        reset_n, hsel, hwrite, hreadyout, hresp;
   logic        cmp_below_ok, cmp_above_ok, data_ready, irq;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0]  htrans, pmode;
   logic [2:0]  hsize;
   logic [7:0]  dac_code, result_code;
   int          level, bad_count, n_checks, m, k, s;
   // ****************************************************************
   // clock, design and far side
   // ****************************************************************
   always #2 core_clk = ~core_clk;
   udtadc_top udtadc_top_inst (.core_clk(core_clk), .reset_n(reset_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .cmp_below_ok(cmp_below_ok), .cmp_above_ok(cmp_above_ok),
      .dac_code(dac_code), .result_code(result_code),
      .data_ready(data_ready), .irq(irq));
   udtadc_partner udtadc_partner_inst (.dac_code(dac_code), .mode(pmode),
      .level(level), .cmp_below_ok(cmp_below_ok),
      .cmp_above_ok(cmp_above_ok));
   // ****************************************************************
   // checks, bus cycles and model
   // ****************************************************************
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task cmp_word(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmp_bit(input logic got, input logic exp);
      cmp_word({31'h0, got}, {31'h0, exp});
   endtask
   // wait for hready high at an edge, bounded
   task wait_hr;
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         stop_test;
      end
   endtask
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, a};
      hwrite <= wr;
      wait_hr;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_hr;
      d = hrdata;
   endtask
   task rreg(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      cmp_word(d, exp);
   endtask
   task wait_lock(input int lim);
      int n;
      n = 0;
      // let a new imbalance reach data_ready before looking for lock
      repeat (8) @(posedge core_clk);
      while (data_ready !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         n++;
      end
      if (data_ready !== 1'b1) begin
         bad_count++;
         stop_test;
      end
      repeat (4) @(posedge core_clk);
   endtask
   // model of the settled result: saturated level, mode polarity
   function automatic logic [31:0] exp_res(input int md, input int lv);
      int c;
      c = (lv < 0) ? 0 : (lv > 255) ? 255 : lv;
      exp_res = (md == 0) ? {24'h0, ~8'(c)} : {24'h0, 8'(c)};
   endfunction
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      reset_n = 1'b0;
      {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
      pmode = 2'h0;
      level = 0;
      bad_count = 0;
      n_checks = 0;
      s = $urandom(78);
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      hsize <= 3'h2;
      @(posedge core_clk);
      cmp_word({24'h0, result_code}, 32'h0000_00ff);
      cmp_bit(data_ready, 1'b0);
      for (k = 0; k < 7; k++) begin
         if (k != 2) rreg(8'(k * 4), 32'h0000_0000);
      end
      bus(1'b1, `UDT_OFF_DIV, 32'h0000_000f);
      for (m = 0; m < 4; m++) begin
         level <= $urandom_range(20, 235);
         pmode <= 2'(m);
         bus(1'b1, `UDT_OFF_CTRL, 32'(m * 2 + 1));
         wait_lock(5000);
         cmp_word({24'h0, result_code}, exp_res(m, level));
         rreg(`UDT_OFF_CODE, 32'(level));
         bus(1'b0, `UDT_OFF_STATUS, 32'h0000_0000);
         cmp_bit(d[`UDT_ST_READY], 1'b1);
         if (m == 0) begin
            bus(1'b1, `UDT_OFF_CODE, 32'h0000_0055);
            rreg(`UDT_OFF_CODE, 32'(level));
            rreg(`UDT_OFF_IRQ_STAT, 32'h0000_0003);
            cmp_bit(irq, 1'b0);
            bus(1'b1, `UDT_OFF_IRQ_MASK, 32'h0000_0007);
            repeat (3) @(posedge core_clk);
            cmp_bit(irq, 1'b1);
            bus(1'b1, `UDT_OFF_IRQ_STAT, 32'h0000_0003);
            repeat (3) @(posedge core_clk);
            cmp_bit(irq, 1'b0);
         end
         // slow drift, one step at a time
         for (k = 0; k < 3; k++) begin
            level <= level + 1;
            repeat (40) @(posedge core_clk);
            wait_lock(200);
            cmp_word({24'h0, result_code}, exp_res(m, level));
         end
         repeat (40) @(posedge core_clk);
         cmp_word({24'h0, result_code}, exp_res(m, level));
      end
      // beyond both ends the count must stop, not wrap
      for (k = 0; k < 2; k++) begin
         level <= (k == 0) ? 300 : -5;
         repeat (4400) @(posedge core_clk);
         cmp_word({24'h0, result_code}, exp_res(3, level));
         cmp_bit(data_ready, 1'b0);
         bus(1'b0, `UDT_OFF_STATUS, 32'h0000_0000);
         cmp_bit(d[(k == 0) ? `UDT_ST_AT_MAX : `UDT_ST_AT_MIN], 1'b1);
         bus(1'b0, `UDT_OFF_IRQ_STAT, 32'h0000_0000);
         cmp_bit(d[`UDT_EV_LIMIT], 1'b1);
         cmp_bit(irq, 1'b1);
         // clear the limit flag so the other end must set it afresh
         bus(1'b1, `UDT_OFF_IRQ_STAT, 32'h0000_0004);
      end
      stop_test;
   end
endmodule
`default_nettype wire
